// ===== logic/lccd_timing_gen.v
`timescale 1ns/1ns
`include "lccd_timing_defs.vh"

// Behaviour
// - Phase two is always driven as the exact inverse of phase one.
// - One shared phase pair clocks all three channel registers together.
// - The output reset pulses once per pixel before the pixel appears.
// - The drain gate rises as the first transfer gate turns off and falls during the scan.
// - Exposure runs from the drain gate fall to the next first-transfer-gate fall.
// - Each channel has its own drain gate with its own timing.
// - The drain gate rises in the transfer period, with the first transfer gate fall.
// - The drain gate fall at its set pixel is aligned to a phase clock transition; clearing expEnable drops it on the next clock edge.
// - Phase clocks stay complements and run at a steady rate without abrupt stops.
// - Clocking stops with phase one high and phase two low before transfer.
// - Both transfer gates turn on, then the first turns off.
// - The second transfer gate turns off after the first, before clocking resumes.
// - Complementary clocking resumes after the transfer sequence if run is still high; otherwise the generator returns to idle.
module lccd_timing_gen (
    // Clock and reset
    input  wire                         clock,
    input  wire                         rst_b,
    // Control
    input  wire                         run,
    input  wire [`LCCD_CHANNELS-1:0]    expEnable,
    input  wire [`LCCD_PIX_W-1:0]       expFallPix0,
    input  wire [`LCCD_PIX_W-1:0]       expFallPix1,
    input  wire [`LCCD_PIX_W-1:0]       expFallPix2,
    // Sensor gates
    output reg                          phaseOne,
    output reg                          phaseTwo,
    output reg                          outputReset,
    output reg                          first_transfer_gate,
    output reg                          second_transfer_gate,
    output wire [`LCCD_CHANNELS-1:0]    drainGate,
    // Status
    output reg                          lineStart,
    output reg                          pixelValid
);

    localparam [2:0] ST_IDLE   = 3'd0;
    localparam [2:0] ST_READ   = 3'd1;
    localparam [2:0] ST_TGON   = 3'd2;
    localparam [2:0] ST_TG1OFF = 3'd3;
    localparam [2:0] ST_TG2OFF = 3'd4;

    // Step counts of the transfer-gate sequence and the phase half period
    localparam [`LCCD_STEP_W-1:0] TG_ON_CYC  = `LCCD_TG_ON_CYC;
    localparam [`LCCD_STEP_W-1:0] TG1_CYC    = `LCCD_TG1_OFF_CYC;
    localparam [`LCCD_STEP_W-1:0] TG2_CYC    = `LCCD_TG2_OFF_CYC;
    localparam [1:0]              HALF_CYC   = `LCCD_HALF_CYC;

    reg [2:0]                 state;
    reg [2:0]                 next_state;
    reg [`LCCD_STEP_W-1:0]    step;
    reg [`LCCD_STEP_W-1:0]    next_step;
    reg [1:0]                 halfCnt;
    reg [1:0]                 next_halfCnt;
    reg [`LCCD_PIX_W-1:0]     pixCount;
    reg [`LCCD_PIX_W-1:0]     next_pixCount;
    reg                       next_phaseOne;
    reg                       next_tg1;
    reg                       next_tg2;
    reg                       next_outputReset;
    reg                       next_lineStart;
    reg                       next_pixelValid;
    reg                       lineXfer;
    wire                      halfEdge;
    wire                      pixStep;
    wire [`LCCD_PIX_W-1:0]    fallPix [0:`LCCD_CHANNELS-1];

    // Fall points gathered so the channel loop can index them
    assign fallPix[0] = expFallPix0;
    assign fallPix[1] = expFallPix1;
    assign fallPix[2] = expFallPix2;

    // Phase toggles at a fixed half period; phase one high ends a full pixel
    assign halfEdge = (halfCnt == HALF_CYC - 2'd1);
    assign pixStep  = (state == ST_READ) && halfEdge && !phaseOne;

    // Half-period counter runs only while reading, so the pair parks cleanly
    always @* begin
        next_halfCnt = 2'b00;
        if (state == ST_READ && !halfEdge) begin
            next_halfCnt = halfCnt + 2'b01;
        end
    end

    always @* begin
        next_state       = state;
        next_step        = step;
        next_pixCount    = pixCount;
        next_phaseOne    = phaseOne;
        next_tg1         = first_transfer_gate;
        next_tg2         = second_transfer_gate;
        next_outputReset = 1'b0;
        next_lineStart   = 1'b0;
        next_pixelValid  = 1'b0;
        lineXfer         = 1'b0;
        case (state)
            ST_IDLE: begin
                next_phaseOne = 1'b1;
                if (run) begin
                    next_state = ST_TGON;
                    next_step  = `LCCD_STEP_RST;
                end
            end
            ST_READ: begin
                if (halfEdge) begin
                    next_phaseOne = !phaseOne;
                    if (pixStep) begin
                        next_pixCount   = pixCount + 1'b1;
                        next_pixelValid = 1'b1;
                    end
                    if (phaseOne) begin
                        next_outputReset = 1'b1;
                    end
                    if (pixStep && pixCount == `LCCD_PIX_PER_LINE - 1'b1) begin
                        next_state = ST_TGON;
                        next_step  = `LCCD_STEP_RST;
                    end
                end
            end
            ST_TGON: begin
                next_tg1  = 1'b1;
                next_tg2  = 1'b1;
                next_step = step + 1'b1;
                // Gates rise one edge after entry, so count one further
                if (step == TG_ON_CYC) begin
                    next_state = ST_TG1OFF;
                    next_step  = `LCCD_STEP_RST;
                    next_tg1   = 1'b0;
                    lineXfer   = 1'b1;
                end
            end
            ST_TG1OFF: begin
                next_step = step + 1'b1;
                if (step == TG1_CYC - 1'b1) begin
                    next_tg2   = 1'b0;
                    next_state = ST_TG2OFF;
                    next_step  = `LCCD_STEP_RST;
                end
            end
            ST_TG2OFF: begin
                next_step = step + 1'b1;
                if (step == TG2_CYC - 1'b1) begin
                    next_state     = run ? ST_READ : ST_IDLE;
                    next_pixCount  = `LCCD_PIX_RST;
                    next_lineStart = run;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            state                <= ST_IDLE;
            step                 <= `LCCD_STEP_RST;
            halfCnt              <= 2'b00;
            pixCount             <= `LCCD_PIX_RST;
        end else begin
            state                <= next_state;
            step                 <= next_step;
            halfCnt              <= next_halfCnt;
            pixCount             <= next_pixCount;
        end
    end

    // Every sensor gate comes straight from a flip-flop, free of glitches
    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            phaseOne             <= 1'b1;
            phaseTwo             <= 1'b0;
            outputReset          <= 1'b0;
            first_transfer_gate  <= 1'b0;
            second_transfer_gate <= 1'b0;
            lineStart            <= 1'b0;
            pixelValid           <= 1'b0;
        end else begin
            phaseOne             <= next_phaseOne;
            phaseTwo             <= !next_phaseOne;
            outputReset          <= next_outputReset;
            first_transfer_gate  <= next_tg1;
            second_transfer_gate <= next_tg2;
            lineStart            <= next_lineStart;
            pixelValid           <= next_pixelValid;
        end
    end

    genvar ch;
    generate
        for (ch = 0; ch < `LCCD_CHANNELS; ch = ch + 1) begin : gChan
            lccd_drain_gate uDrain (
                .clock      (clock),
                .rst_b      (rst_b),
                .lineXfer   (lineXfer),
                .pixStep    (pixStep),
                .pixCount   (pixCount),
                .expEnable  (expEnable[ch]),
                .expFallPix (fallPix[ch]),
                .drainGate  (drainGate[ch])
            );
        end
    endgenerate

endmodule // lccd_timing_gen

// ===== logic/lccd_timing_defs.vh
`ifndef LCCD_TIMING_DEFS_VH
`define LCCD_TIMING_DEFS_VH

// Clock rate and derived cycle counts
`define LCCD_CLK_MHZ        20
`define LCCD_CHANNELS       3
// Half period of the phase pair, in clock cycles (20 MHz / 4 = 5 MHz pixel rate)
`define LCCD_HALF_CYC       2'h2
// Transfer-gate step times in clock cycles (1000 ns, 500 ns, 500 ns at 20 MHz)
`define LCCD_TG_ON_CYC      8'h14
`define LCCD_TG1_OFF_CYC    8'h0A
`define LCCD_TG2_OFF_CYC    8'h0A
// Pixels clocked per line, width of pixel counters
`define LCCD_PIX_W          14
`define LCCD_PIX_PER_LINE   14'h1F80
// Counter widths
`define LCCD_STEP_W         8
// Reset values
`define LCCD_PIX_RST        14'h0000
`define LCCD_STEP_RST       8'h00

`endif

// ===== logic/lccd_drain_gate.v
`timescale 1ns/1ns
`include "lccd_timing_defs.vh"

// One drain gate per channel, raised at the transfer and dropped at its own pixel.
module lccd_drain_gate (
    // Clock and reset
    input  wire                     clock,
    input  wire                     rst_b,
    // Line timing
    input  wire                     lineXfer,
    input  wire                     pixStep,
    input  wire [`LCCD_PIX_W-1:0]   pixCount,
    // Per-channel setup
    input  wire                     expEnable,
    input  wire [`LCCD_PIX_W-1:0]   expFallPix,
    // Drain gate drive
    output reg                      drainGate
);

    reg next_drainGate;

    always @* begin
        next_drainGate = drainGate;
        if (lineXfer) begin
            next_drainGate = expEnable;
        end else if (!expEnable) begin
            next_drainGate = 1'b0;
        end else if (pixStep && pixCount == expFallPix) begin
            next_drainGate = 1'b0;
        end
    end

    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            drainGate <= 1'b0;
        end else begin
            drainGate <= next_drainGate;
        end
    end

endmodule // lccd_drain_gate

// ===== tb/lccd_timing_gen_asserts.sv
`timescale 1ns/1ns
`include "lccd_timing_defs.vh"

module lccd_timing_gen_asserts (
    // Clock and reset
    input  wire                      clock,
    input  wire                      rst_b,
    // Control
    input  wire                      run,
    input  wire [`LCCD_CHANNELS-1:0] expEnable,
    // Sensor gates and status
    input  wire                      phaseOne,
    input  wire                      phaseTwo,
    input  wire                      outputReset,
    input  wire                      first_transfer_gate,
    input  wire                      second_transfer_gate,
    input  wire [`LCCD_CHANNELS-1:0] drainGate,
    input  wire                      lineStart,
    input  wire                      pixelValid
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);

    sequence tgStart;
        $rose(first_transfer_gate) && second_transfer_gate;
    endsequence
    sequence tgFinish;
        ##20 ($fell(first_transfer_gate) && second_transfer_gate) ##10 $fell(second_transfer_gate);
    endsequence

    AST_PHASE_INV: assert property (phaseTwo == !phaseOne)
        else $error("phase pair not complementary");
    AST_PARK: assert property ((first_transfer_gate || second_transfer_gate) |-> phaseOne && !phaseTwo)
        else $error("phases not parked during transfer");
    AST_TG_SEQ: assert property (tgStart |-> tgFinish)
        else $error("transfer gate order or timing wrong");
    AST_RESUME: assert property ($fell(second_transfer_gate) |-> ##10 (lineStart == $past(run)))
        else $error("readout did not resume");
    AST_DRAIN_RISE: assert property ($fell(first_transfer_gate) |-> drainGate == expEnable)
        else $error("drain gate not raised at transfer");
    AST_DRAIN_IDLE: assert property (~|(drainGate & ~expEnable & ~$past(expEnable)))
        else $error("unused drain gate went high");
    AST_DRAIN_ALIGN: assert property (|(~drainGate & $past(drainGate))
        |-> ($past(phaseOne) != $past(phaseOne, 2)) || (phaseOne != $past(phaseOne)))
        else $error("drain gate fall not aligned to phases");
    AST_RESET_PULSE: assert property (outputReset |-> $fell(phaseOne) ##1 !outputReset)
        else $error("output reset pulse misplaced");
    AST_PHASE_RATE: assert property ($fell(phaseOne) |=> !phaseOne ##1 phaseOne)
        else $error("phase one low time wrong");
    AST_PIX_VALID: assert property ($fell(phaseTwo) |-> pixelValid)
        else $error("pixel valid missing after phase two fall");
endmodule // lccd_timing_gen_asserts

bind lccd_timing_gen lccd_timing_gen_asserts u_chk (
    .clock(clock), .rst_b(rst_b), .run(run), .expEnable(expEnable), .phaseOne(phaseOne),
    .phaseTwo(phaseTwo), .outputReset(outputReset), .first_transfer_gate(first_transfer_gate),
    .second_transfer_gate(second_transfer_gate), .drainGate(drainGate),
    .lineStart(lineStart), .pixelValid(pixelValid));

// ===== tb/lccd_sensor_model.sv
`timescale 1ns/1ns
`include "lccd_timing_defs.vh"

// Sensor has no clock; it only reacts to gate edges
module lccd_sensor_model (
    // Gates
    input  wire                        rst_b,
    input  wire                        phaseTwo,
    input  wire                        outputReset,
    input  wire                        first_transfer_gate,
    input  wire [`LCCD_CHANNELS-1:0]   drainGate,
    // Observations
    output int                         lastLine,
    output int                         noReset,
    output int                         fallAt [3],
    output logic [`LCCD_CHANNELS-1:0]  drainSeen
);
    int   pixOut = 0;
    logic resetSeen = 1'b0;
    initial begin
        lastLine = 0;
        noReset = 0;
        drainSeen = 3'b000;
    end
    always @(posedge outputReset) resetSeen = 1'b1;
    always @(negedge phaseTwo) if (rst_b) begin
        // sense node must be reset first
        if (!resetSeen) noReset++;
        resetSeen = 1'b0;
        pixOut++;
    end
    always @(posedge first_transfer_gate) begin
        lastLine = pixOut;
        pixOut = 0;
    end
    // independent drain per channel; let the same-edge pixel shift count first
    always @(negedge drainGate[0]) if (rst_b) #1 fallAt[0] = pixOut;
    always @(negedge drainGate[1]) if (rst_b) #1 fallAt[1] = pixOut;
    always @(negedge drainGate[2]) if (rst_b) #1 fallAt[2] = pixOut;
    always @(drainGate) if (rst_b) drainSeen = drainSeen | drainGate;
endmodule // lccd_sensor_model

// ===== tb/lccd_timing_gen_tb.sv
`timescale 1ns/1ns
`include "lccd_timing_defs.vh"
`define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin error_cnt++; \
    $display("ERROR %s exp %0d got %0d", nm, ex, got); end end

module lccd_timing_gen_tb;
    logic        clock = 1'b0;
    logic        rst_b = 1'b0;
    logic        run = 1'b0;
    logic [2:0]  expEnable = 3'b000;
    logic [13:0] fall0 = 14'h0064;
    logic [13:0] fall1 = 14'h0010;
    logic [13:0] fall2 = 14'h1F40;
    wire         phaseOne, phaseTwo, outputReset, tgA, tgB, lineStart, pixelValid;
    wire  [2:0]  drainGate;
    int          error_cnt = 0, checks_done = 0, cycles = 0, lastLine, noReset, fallAt [3];
    logic [2:0]  drainSeen;
    int          validCnt = 0, startCnt = 0;

    always #25 clock = ~clock;

    lccd_timing_gen u_dut (.clock(clock), .rst_b(rst_b), .run(run), .expEnable(expEnable),
        .expFallPix0(fall0), .expFallPix1(fall1), .expFallPix2(fall2), .phaseOne(phaseOne),
        .phaseTwo(phaseTwo), .outputReset(outputReset), .first_transfer_gate(tgA),
        .second_transfer_gate(tgB), .drainGate(drainGate), .lineStart(lineStart),
        .pixelValid(pixelValid));
    lccd_sensor_model u_sensor (.rst_b(rst_b), .phaseTwo(phaseTwo), .outputReset(outputReset),
        .first_transfer_gate(tgA), .drainGate(drainGate), .lastLine(lastLine),
        .noReset(noReset), .fallAt(fallAt), .drainSeen(drainSeen));

    task final_report;
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    // One line is about 32300 cycles
    always @(posedge clock) begin
        cycles++;
        if (cycles == 40000) begin
            error_cnt++;
            final_report;
        end
    end

    // Status pulses as seen on the clock edge that samples them
    always @(posedge clock) begin
        if (pixelValid) validCnt++;
        if (lineStart) startCnt++;
    end

    task t_reset_state;
        `CHK("phaseOne", 1'b1, phaseOne)
        `CHK("phaseTwo", 1'b0, phaseTwo)
        `CHK("gates", 6'h00, {outputReset, tgA, tgB, drainGate})
    endtask

    // Full line with channels 0 and 2 shortened, channel 1 full exposure
    task t_full_line;
        @(negedge clock) run = 1'b1;
        expEnable = 3'b101;
        @(posedge tgA);
        @(posedge tgA);
        @(negedge clock);
        `CHK("pixels per line", 8064, lastLine)
        `CHK("pixel valid pulses", 8064, validCnt)
        `CHK("line starts", 1, startCnt)
        `CHK("pixels without reset", 0, noReset)
        `CHK("ch0 drain fall pixel", 101, fallAt[0])
        `CHK("drain fall spacing", 7900, fallAt[2] - fallAt[0])
        `CHK("drain gates used", 3'b101, drainSeen)
    endtask

    // Reset in mid transfer, restart with only channel 1 controlled, then stop
    task t_mid_reset;
        @(negedge clock) rst_b = 1'b0;
        #1 t_reset_state;
        @(negedge clock) rst_b = 1'b1;
        expEnable = 3'b010;
        @(negedge tgA);
        #1 `CHK("drain at transfer", 3'b010, drainGate)
        @(negedge clock) run = 1'b0;
        repeat (50) @(negedge clock);
        `CHK("parked phase one", 1'b1, phaseOne)
        `CHK("transfer gates off", 2'b00, {tgA, tgB})
        `CHK("no restart without run", 1, startCnt)
    endtask

    initial begin
        repeat (4) @(negedge clock);
        t_reset_state;
        rst_b = 1'b1;
        t_full_line;
        t_mid_reset;
        final_report;
    end
endmodule // lccd_timing_gen_tb
